// file: rtl/pfs_status.sv
// Function status register with command enables, SERR and INTx drive
module pfs_status
  import pfs_pkg::*;
// What this block does
// RL1: Write one clears flag, zero keeps
// RL2: Bit 15 set on address/data parity error
// RL3: Bit 14 set when enabled SERR driven
// RL4: Bit 13 set on received master abort
// RL5: Bit 12 set on received target abort
// RL6: Bit 11 set on signaled target abort
// RL7: Bits 10-9 read 01b, medium DEVSEL
// RL8: Bit 8 needs PERR, mastership, parity enable
// RL9: Bit 7 reads zero
// RL10: Bit 6 reads zero
// RL11: Bit 5 reads zero, not 66 MHz
// RL12: Bit 4 reads one, capabilities list
// RL13: INTx only when status set, not disabled
// RL14: Interrupt status ignores disable bit
// RL15: Status set only for enabled conditions
// RL16: Bits 2-0 read zero, writes ignored
// RL17: Interrupt disable blocks INTx assertion
// RL18: SERR driven only while enable set
// RL19: Set beats simultaneous clear
(
  // Clock, enable, reset
  input wire logic clk,
  input wire logic ce,
  input wire logic rst,
  // Configuration access
  input wire pfs_cfg_req_t cfg_req,
  input wire logic cfg_rd,
  output logic [15:0] cfg_rdata,
  // Bus events
  input wire pfs_events_t events,
  // Interrupt sources: raw condition and its per-event enable
  input wire logic int_cond,
  input wire logic int_cond_en,
  // Pins (active low; output enable high while driving)
  output logic serr_n_out,
  output logic serr_n_oe,
  output logic intx_n_out,
  output logic intx_n_oe,
  // Visible state
  output logic [15:0] status_out,
  output logic [15:0] command_out
);
  logic [15:0] command_reg;
  logic int_status_reg;
  logic serr_drive_reg;
  logic [PFS_NUM_FLAGS-1:0] flag_set;
  logic [PFS_NUM_FLAGS-1:0] flag_clr;
  logic [PFS_NUM_FLAGS-1:0] flag_q;
  logic [15:0] status_next;
  logic wr_status;
  logic wr_command;
  logic [15:0] wr_bits;

  function automatic logic [15:0] pfs_lane_mask(input logic [1:0] be);
    pfs_lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // Offset decode shared by the write and read paths
  function automatic logic pfs_hit(input logic [7:0] offset, input logic [7:0] target);
    pfs_hit = offset == target;
  endfunction

  assign wr_status = cfg_req.wr && pfs_hit(cfg_req.offset, PFS_STATUS_OFFSET);
  assign wr_command = cfg_req.wr && pfs_hit(cfg_req.offset, PFS_COMMAND_OFFSET);
  // Only enabled byte lanes may clear anything
  assign wr_bits = cfg_req.wdata & pfs_lane_mask(cfg_req.be);

  // Flag order: 5 parity, 4 signaled_system_error, 3 received_master_abort, 2 tabort rcvd, 1 tabort sent, 0 data parity
  assign flag_set[5] = events.addr_parity_err || events.data_parity_err; // [RL2]
  assign flag_set[4] = serr_drive_reg; // [RL3]
  assign flag_set[3] = events.master_abort; // [RL4]
  assign flag_set[2] = events.target_abort_rcvd; // [RL5]
  assign flag_set[1] = events.target_abort_sent; // [RL6]
  assign flag_set[0] = events.perr_seen && events.was_master && command_reg[PFS_C_PARITY_RESPONSE_ENABLE]; // [RL8]

  localparam int FLAG_BIT [PFS_NUM_FLAGS] = '{PFS_B_DATA_PAR, PFS_B_SIGNALED_TARGET_ABORT, PFS_B_RECEIVED_TARGET_ABORT,
                                               PFS_B_RECEIVED_MASTER_ABORT, PFS_B_SIGNALED_SYSTEM_ERROR, PFS_B_DETECTED_PARITY_ERROR};

  genvar gi;
  generate
    for (gi = 0; gi < PFS_NUM_FLAGS; gi++) begin : g_flag
      assign flag_clr[gi] = wr_status && wr_bits[FLAG_BIT[gi]]; // [RL1]
      pfs_w1c_flag u_flag (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .set_evt(flag_set[gi]),
        .clr_wr(flag_clr[gi]),
        .flag(flag_q[gi])
      );
    end
  endgenerate

  // Fixed fields are composed here, never stored, so writes cannot touch them
  always_comb begin
    status_next = 16'h0000; // [RL9] [RL10] [RL11] [RL16]
    status_next[PFS_B_DETECTED_PARITY_ERROR] = flag_q[5];
    status_next[PFS_B_SIGNALED_SYSTEM_ERROR] = flag_q[4];
    status_next[PFS_B_RECEIVED_MASTER_ABORT] = flag_q[3];
    status_next[PFS_B_RECEIVED_TARGET_ABORT] = flag_q[2];
    status_next[PFS_B_SIGNALED_TARGET_ABORT] = flag_q[1];
    status_next[PFS_B_DEVSEL_LO +: 2] = PFS_DEVSEL_MEDIUM; // [RL7]
    status_next[PFS_B_DATA_PAR] = flag_q[0];
    status_next[PFS_B_CAP_LIST] = 1'b1; // [RL12]
    status_next[PFS_B_INT_STATUS] = int_status_reg;
  end

  // Command: only the writable enables are stored
  always_ff @(posedge clk) begin
    if (rst) begin
      command_reg <= PFS_COMMAND_RESET;
    end else if (ce && wr_command) begin
      command_reg <= (command_reg & ~(PFS_COMMAND_RW_MASK & pfs_lane_mask(cfg_req.be)))
                   | (cfg_req.wdata & PFS_COMMAND_RW_MASK & pfs_lane_mask(cfg_req.be));
    end
  end

  // Live status tracks enabled condition; disable bit deliberately not consulted
  always_ff @(posedge clk) begin
    if (rst) begin
      int_status_reg <= 1'b0;
    end else if (ce) begin
      int_status_reg <= int_cond && int_cond_en; // [RL14] [RL15]
    end
  end

  // SERR only after a serr_request event and only while enabled
  always_ff @(posedge clk) begin
    if (rst) begin
      serr_drive_reg <= 1'b0;
    end else if (ce) begin
      serr_drive_reg <= events.serr_request && command_reg[PFS_C_SERR_EN]; // [RL18]
    end
  end

  // Pins registered; SERR pulses one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      serr_n_out <= 1'b1;
      serr_n_oe <= 1'b0;
      intx_n_out <= 1'b1;
      intx_n_oe <= 1'b0;
    end else if (ce) begin
      serr_n_out <= !serr_drive_reg;
      serr_n_oe <= serr_drive_reg;
      intx_n_out <= !(int_status_reg && !command_reg[PFS_C_INT_DISABLE]); // [RL13] [RL17]
      intx_n_oe <= int_status_reg && !command_reg[PFS_C_INT_DISABLE]; // [RL13] [RL17]
    end
  end

  // Read data and visible copies; reads have no side effects
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rdata <= 16'h0000;
      status_out <= PFS_STATUS_RESET;
      command_out <= PFS_COMMAND_RESET;
    end else if (ce) begin
      status_out <= status_next;
      command_out <= command_reg;
      if (cfg_rd && pfs_hit(cfg_req.offset, PFS_STATUS_OFFSET)) begin
        cfg_rdata <= status_next; // [RL1]
      end else if (cfg_rd && pfs_hit(cfg_req.offset, PFS_COMMAND_OFFSET)) begin
        cfg_rdata <= command_reg;
      end else begin
        cfg_rdata <= 16'h0000;
      end
    end
  end

  // Assertions
  a_set_beats_clear: assert property (@(posedge clk) disable iff (rst) // [RL19]
    ce && flag_set[3] && flag_clr[3] |=> flag_q[3]) else $error("master abort lost on clear");
  a_w1c_clears: assert property (@(posedge clk) disable iff (rst) // [RL1]
    ce && flag_clr[2] && !flag_set[2] |=> !flag_q[2]) else $error("flag not cleared");
  a_fixed_bits: assert property (@(posedge clk) disable iff (rst) // [RL7]
    (status_next & 16'h06F7) == 16'h0210) else $error("fixed status bits wrong");
  a_master_data_parity_error_gate: assert property (@(posedge clk) disable iff (rst) // [RL8]
    ce && !$past(flag_q[0]) && flag_q[0] |-> $past(command_reg[PFS_C_PARITY_RESPONSE_ENABLE]) && $past(events.was_master))
    else $error("data parity set without cause");
  a_intx_gate: assert property (@(posedge clk) disable iff (rst) // [RL13]
    !intx_n_out |-> $past(int_status_reg) && !$past(command_reg[PFS_C_INT_DISABLE])) else $error("intx without cause");
  a_serr_gate: assert property (@(posedge clk) disable iff (rst) // [RL18]
    ce && events.serr_request && !command_reg[PFS_C_SERR_EN] |=> !serr_drive_reg) else $error("serr while disabled");
  a_signaled_system_error_set: assert property (@(posedge clk) disable iff (rst) // [RL3]
    ce && serr_drive_reg |=> flag_q[4]) else $error("signaled_system_error not set");
  a_int_status: assert property (@(posedge clk) disable iff (rst) // [RL15]
    ce && int_cond && !int_cond_en |=> !int_status_reg) else $error("int status set while event disabled");
  a_parity_set: assert property (@(posedge clk) disable iff (rst) // [RL2]
    ce && events.addr_parity_err |=> flag_q[5]) else $error("parity flag not set");
  a_received_master_abort_set: assert property (@(posedge clk) disable iff (rst) // [RL4]
    ce && events.master_abort |=> flag_q[3]) else $error("master abort flag not set");
  a_tabort_rcvd: assert property (@(posedge clk) disable iff (rst) // [RL5]
    ce && events.target_abort_rcvd |=> flag_q[2]) else $error("received target abort flag not set");
  a_tabort_sent: assert property (@(posedge clk) disable iff (rst) // [RL6]
    ce && events.target_abort_sent |=> flag_q[1]) else $error("signaled target abort flag not set");
  a_int_track: assert property (@(posedge clk) disable iff (rst) // [RL14]
    ce && int_cond && int_cond_en |=> int_status_reg) else $error("int status not tracking condition");
  a_intx_masked: assert property (@(posedge clk) disable iff (rst) // [RL17]
    ce && command_reg[PFS_C_INT_DISABLE] |=> !intx_n_oe) else $error("intx driven while disabled");
  c_parity: cover property (@(posedge clk) disable iff (rst) flag_q[5] ##1 !flag_q[5]);
  c_set_clear: cover property (@(posedge clk) disable iff (rst) ce && flag_set[3] && flag_clr[3]);
  c_intx: cover property (@(posedge clk) disable iff (rst) !intx_n_out);
  c_serr: cover property (@(posedge clk) disable iff (rst) !serr_n_out);
endmodule

// file: rtl/pfs_pkg.sv
// Package: status register offsets, field positions, reset value and carriers
package pfs_pkg;
  localparam logic [7:0] PFS_STATUS_OFFSET = 8'h06;
  localparam logic [7:0] PFS_COMMAND_OFFSET = 8'h04;
  localparam logic [15:0] PFS_STATUS_RESET = 16'h0210;
  localparam logic [15:0] PFS_COMMAND_RESET = 16'h0000;
  localparam logic [15:0] PFS_COMMAND_RW_MASK = 16'h0546;
  // Status field positions
  localparam int PFS_B_DETECTED_PARITY_ERROR = 15;
  localparam int PFS_B_SIGNALED_SYSTEM_ERROR = 14;
  localparam int PFS_B_RECEIVED_MASTER_ABORT = 13;
  localparam int PFS_B_RECEIVED_TARGET_ABORT = 12;
  localparam int PFS_B_SIGNALED_TARGET_ABORT = 11;
  localparam int PFS_B_DEVSEL_LO = 9;
  localparam int PFS_B_DATA_PAR = 8;
  localparam int PFS_B_CAP_LIST = 4;
  localparam int PFS_B_INT_STATUS = 3;
  localparam logic [1:0] PFS_DEVSEL_MEDIUM = 2'h1;
  // Command field positions
  localparam int PFS_C_INT_DISABLE = 10;
  localparam int PFS_C_SERR_EN = 8;
  localparam int PFS_C_PARITY_RESPONSE_ENABLE = 6;
  localparam int PFS_NUM_FLAGS = 6;

  // Error events from the bus interface, one-cycle pulses
  typedef struct packed {
    logic addr_parity_err;
    logic data_parity_err;
    logic serr_request;
    logic master_abort;
    logic target_abort_rcvd;
    logic target_abort_sent;
    logic perr_seen;
    logic was_master;
  } pfs_events_t;

  // Configuration access port
  typedef struct packed {
    logic wr;
    logic [7:0] offset;
    logic [1:0] be;
    logic [15:0] wdata;
  } pfs_cfg_req_t;
endpackage

// file: rtl/pfs_w1c_flag.sv
// One sticky flag, set by hardware, cleared by writing one
module pfs_w1c_flag
  import pfs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic set_evt,
  input wire logic clr_wr,
  // State
  output logic flag
);
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (set_evt) begin
        flag <= 1'b1; // [RL19]
      end else if (clr_wr) begin
        flag <= 1'b0; // [RL1]
      end
    end
  end
endmodule

// file: dv/pfs_bus_agent.sv
// Bus-side agent that turns a bench request into one-cycle event pulses
module pfs_bus_agent
  import pfs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request from the bench
  input wire logic fire,
  input wire pfs_events_t req,
  // Events toward the status block
  output pfs_events_t events
);
  timeunit 1ns;
  timeprecision 1ns;
  // Registered, so each event lasts exactly one cycle and moves just after an edge
  always @(posedge clk) begin
    events <= fire ? req : '0;
  end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the function status register
module tb_top
  import pfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] R = PFS_STATUS_RESET;
  logic clk = 0, rst = 1, ce = 1, cfg_rd = 0, int_cond = 0, int_cond_en = 0, fire = 0, rd_seen = 0;
  logic serr_n_out, serr_n_oe, intx_n_out, intx_n_oe;
  logic [15:0] cfg_rdata, status_out, command_out;
  pfs_cfg_req_t cfg_req = '0;
  pfs_events_t ev_req = '0;
  pfs_events_t events;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int samples_checked = 0;
  int serr_cycles = 0;
  pfs_events_t ev[7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h03};
  int bit_of[7] = '{15, 15, 14, 13, 12, 11, 8};
  always #5 clk = ~clk;
  pfs_status DUT(.clk(clk), .ce(ce), .rst(rst), .cfg_req(cfg_req), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .events(events), .int_cond(int_cond), .int_cond_en(int_cond_en), .serr_n_out(serr_n_out),
    .serr_n_oe(serr_n_oe), .intx_n_out(intx_n_out), .intx_n_oe(intx_n_oe), .status_out(status_out),
    .command_out(command_out));
  pfs_bus_agent agent(.clk(clk), .fire(fire), .req(ev_req), .events(events));
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] off, input logic [15:0] d);
    @(negedge clk);
    cfg_req = '{1'b1, off, 2'h3, d};
    @(negedge clk);
    cfg_req.wr = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // Expected value is noted here, compared by the watcher below
  task automatic rd(input logic [7:0] off, input logic [15:0] want);
    @(negedge clk);
    cfg_req.offset = off;
    cfg_rd = 1'b1;
    exp_q.push_back(want);
    @(negedge clk);
    cfg_rd = 1'b0;
    @(negedge clk);
  endtask
  task automatic pulse(input pfs_events_t e);
    @(negedge clk);
    ev_req = e;
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  always @(posedge clk) rd_seen <= cfg_rd & ce & ~rst;
  // Counts cycles in which the SERR pin is actively pulled low
  always @(negedge clk) begin
    if (!rst && serr_n_oe && !serr_n_out) begin
      serr_cycles++;
    end
  end
  always @(negedge clk) begin
    if (rd_seen) begin
      chk(cfg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  initial begin
    logic [15:0] m;
    void'($urandom(32'h1A00));
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rd(PFS_STATUS_OFFSET, R);
    rd(8'h0C, 16'h0000);
    wr(PFS_COMMAND_OFFSET, 16'hFFFF);
    rd(PFS_COMMAND_OFFSET, PFS_COMMAND_RW_MASK);
    wr(PFS_COMMAND_OFFSET, 16'h0000);
    // Enables off: these must leave the flags alone
    pulse(8'h20);
    pulse(8'h03);
    rd(PFS_STATUS_OFFSET, R);
    wr(PFS_COMMAND_OFFSET, 16'h0140);
    pulse(8'h02);
    rd(PFS_STATUS_OFFSET, R);
    for (int i = 0; i < 7; i++) begin
      m = 16'h0001 << bit_of[i];
      pulse(ev[i]);
      wr(PFS_STATUS_OFFSET, 16'($urandom()) & ~m);
      rd(PFS_STATUS_OFFSET, R | m);
      wr(PFS_STATUS_OFFSET, m);
      rd(PFS_STATUS_OFFSET, R);
    end
    // Event and clearing write land on the same edge
    @(negedge clk);
    ev_req = 8'h10;
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
    cfg_req = '{1'b1, PFS_STATUS_OFFSET, 2'h3, 16'h2000};
    @(negedge clk);
    cfg_req.wr = 1'b0;
    repeat (3) @(negedge clk);
    rd(PFS_STATUS_OFFSET, R | 16'h2000);
    wr(PFS_STATUS_OFFSET, 16'h2000);
    int_cond = 1'b1;
    repeat (4) @(negedge clk);
    rd(PFS_STATUS_OFFSET, R);
    int_cond_en = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'({intx_n_oe, intx_n_out}), 16'h0002);
    rd(PFS_STATUS_OFFSET, R | 16'h0008);
    wr(PFS_COMMAND_OFFSET, 16'h0540);
    chk(16'({intx_n_oe, intx_n_out}), 16'h0001);
    rd(PFS_STATUS_OFFSET, R | 16'h0008);
    chk(status_out, R | 16'h0008);
    chk(command_out, 16'h0540);
    chk(16'(serr_cycles), 16'h0001);
    complete_run();
  end
endmodule
